//--- rtl/twe_consts.svh
// Constants of the three-wire serial memory command port
`ifndef TWE_CONSTS_SVH
`define TWE_CONSTS_SVH
`define TWE_START_BIT 1'h1
`define TWE_OPC_READ 2'h2
`define TWE_OPC_WRITE 2'h1
`define TWE_OPC_ERASE 2'h3
`define TWE_OPC_MISC 2'h0
`define TWE_PAT_ENABLE 2'h3
`define TWE_PAT_ERASE_ALL 2'h2
`define TWE_PAT_WRITE_ALL 2'h1
`define TWE_PAT_DISABLE 2'h0
`define TWE_ALEN_X8 5'h07
`define TWE_ALEN_X16 5'h06
`define TWE_DLEN_X8 5'h08
`define TWE_DLEN_X16 5'h10
`define TWE_ERASED_WORD 16'hFFFF
`define TWE_MEM_BYTES 128
`define TWE_CORE_PERIOD_NS 10
`define TWE_MIN_SELECT_LOW_NS 250
`define TWE_MIN_SELECT_LOW_CYC ((`TWE_MIN_SELECT_LOW_NS + `TWE_CORE_PERIOD_NS - 1) / `TWE_CORE_PERIOD_NS)
`define TWE_PROGRAM_CYCLE_MS 5
`define TWE_PROGRAM_CYCLE_CYC (`TWE_PROGRAM_CYCLE_MS * 1000000 / `TWE_CORE_PERIOD_NS)
`define TWE_POLL_LIMIT_CYC (2 * `TWE_PROGRAM_CYCLE_CYC)
`define TWE_SCLK_HALF_CYC 3'h4
`define TWE_CNT_W 24
`endif

//--- rtl/twe_pkg.sv
// Types shared by both ends of the serial memory link
package twe_pkg;
  typedef enum logic [2:0] {OP_READ, OP_ENABLE, OP_ERASE, OP_WRITE, OP_ERASE_ALL,
                            OP_WRITE_ALL, OP_DISABLE} twe_op_e;
  typedef enum logic [2:0] {D_IDLE, D_OPC, D_ADDR, D_DATA, D_READ, D_DONE} twe_dev_st_e;
  typedef enum logic [2:0] {H_IDLE, H_SHIFT, H_RECV, H_GAP, H_POLL, H_END} twe_host_st_e;
endpackage : twe_pkg

//--- rtl/twe_link_if.sv
// Three-wire link between host controller and serial memory
`timescale 1ns/1ps
interface twe_link_if;
  logic chip_select;
  logic serial_clock_in;
  logic serial_data_in;
  logic serial_data_out;
  logic serial_data_out_oe;
  modport host (output chip_select, output serial_clock_in, output serial_data_in,
                input serial_data_out, input serial_data_out_oe);
  modport dev (input chip_select, input serial_clock_in, input serial_data_in,
               output serial_data_out, output serial_data_out_oe);
endinterface : twe_link_if

//--- rtl/twe_device.sv
// Serial memory end: command decoder, array, self-timed program cycle
`timescale 1ns/1ps
`include "twe_consts.svh"
module twe_device #(
  parameter int unsigned PROG_CYCLES = `TWE_PROGRAM_CYCLE_CYC,
  parameter bit WORD_ONLY = 1'b0
) (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic ORGANIZATION_SELECT,
  twe_link_if.dev LINK,
  output logic BUSY,
  output logic PROG_ENABLED
);
  import twe_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  twe_dev_st_e st_r;
  logic [4:0] cnt_r;
  logic [1:0] op_r;
  logic [6:0] addr_r;
  logic [15:0] sh_r;
  logic [15:0] rd_r;
  logic do_r;
  logic rd_act_r;
  logic en_r;
  logic tgl_r;
  logic [7:0] mem_r [`TWE_MEM_BYTES];
  logic frm_rst_n;
  logic word_org;
  logic [4:0] alen;
  logic [4:0] dlen;
  logic [6:0] a_full;
  logic [15:0] d_full;
  logic [1:0] sel;
  logic addr_last;
  logic data_last;
  logic erase_go;
  logic erase_whole_array_cmd_go;
  logic wr_go;
  logic prog_go;
  logic pg_all;
  logic [6:0] pg_addr;
  logic [15:0] pg_data;
  logic [15:0] rd_word;
  logic org_s1_r;
  logic org_s2_r;
  logic cs_s1_r;
  logic cs_s2_r;
  logic tg_s1_r;
  logic tg_s2_r;
  logic tg_s3_r;
  logic busy_r;
  logic armed_r;
  logic stat_r;
  logic [`TWE_CNT_W-1:0] tmr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Link clock domain: command decode

  // Select low ends the frame at once; the serial clock stops between frames
  assign frm_rst_n = ARST_N & LINK.chip_select;
  assign word_org = WORD_ONLY | org_s2_r;
  assign alen = word_org ? `TWE_ALEN_X16 : `TWE_ALEN_X8;
  assign dlen = word_org ? `TWE_DLEN_X16 : `TWE_DLEN_X8;
  assign a_full = {addr_r[5:0], LINK.serial_data_in};
  assign d_full = {sh_r[14:0], LINK.serial_data_in};
  // Two leading address bits qualify the 00 opcode group
  assign sel = word_org ? a_full[5:4] : a_full[6:5];
  assign addr_last = (st_r == D_ADDR) && (cnt_r == alen - 5'h01);
  assign data_last = (st_r == D_DATA) && (cnt_r == dlen - 5'h01);

  // Accepted programming actions; all of them need the enable latch
  always_comb
  begin
    erase_go = addr_last && (op_r == `TWE_OPC_ERASE) && en_r;
    erase_whole_array_cmd_go = addr_last && (op_r == `TWE_OPC_MISC) && (sel == `TWE_PAT_ERASE_ALL) && en_r;
    wr_go = data_last && en_r;
    prog_go = erase_go | erase_whole_array_cmd_go | wr_go;
    pg_all = erase_whole_array_cmd_go | (wr_go && (op_r == `TWE_OPC_MISC));
    pg_addr = addr_last ? a_full : addr_r;
    pg_data = (erase_go | erase_whole_array_cmd_go) ? `TWE_ERASED_WORD : d_full;
  end

  // Read word, left aligned so the MSB leaves first
  always_comb
  begin
    if (word_org)
    begin
      rd_word = {mem_r[{a_full[5:0], 1'b1}], mem_r[{a_full[5:0], 1'b0}]};
    end
    else
    begin
      rd_word = {mem_r[a_full], 8'h00};
    end
  end

  // Frame sequencer: start marker, opcode, address, data or read-out
  always_ff @(posedge LINK.serial_clock_in or negedge frm_rst_n)
  begin
    if (!frm_rst_n)
    begin
      st_r <= D_IDLE;
      cnt_r <= 5'h00;
      op_r <= 2'h0;
      addr_r <= 7'h00;
      sh_r <= 16'h0000;
      rd_r <= 16'h0000;
      do_r <= 1'b0;
      rd_act_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_r + 5'h01;
      unique case (st_r)
        D_IDLE:
        begin
          cnt_r <= 5'h00;
          if (LINK.serial_data_in == `TWE_START_BIT)
          begin
            st_r <= D_OPC;
          end
        end
        D_OPC:
        begin
          op_r <= {op_r[0], LINK.serial_data_in};
          if (cnt_r == 5'h01)
          begin
            cnt_r <= 5'h00;
            st_r <= D_ADDR;
          end
        end
        D_ADDR:
        begin
          addr_r <= a_full;
          if (addr_last)
          begin
            cnt_r <= 5'h00;
            if (op_r == `TWE_OPC_READ)
            begin
              // Dummy zero goes out on this same rising edge
              rd_r <= rd_word;
              do_r <= 1'b0;
              rd_act_r <= 1'b1;
              st_r <= D_READ;
            end
            else if ((op_r == `TWE_OPC_WRITE) ||
                     ((op_r == `TWE_OPC_MISC) && (sel == `TWE_PAT_WRITE_ALL)))
            begin
              st_r <= D_DATA;
            end
            else
            begin
              st_r <= D_DONE;
            end
          end
        end
        D_DATA:
        begin
          sh_r <= d_full;
          if (data_last)
          begin
            st_r <= D_DONE;
          end
        end
        D_READ:
        begin
          do_r <= rd_r[15];
          rd_r <= {rd_r[14:0], 1'b0};
        end
        D_DONE:
        begin
          cnt_r <= 5'h00;
        end
      endcase
    end
  end

  // Enable latch survives frames; only the power-up reset or the disable command clears it
  always_ff @(posedge LINK.serial_clock_in or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      en_r <= 1'b0;
    end
    else if (addr_last && (op_r == `TWE_OPC_MISC))
    begin
      if (sel == `TWE_PAT_ENABLE)
      begin
        en_r <= 1'b1;
      end
      else if (sel == `TWE_PAT_DISABLE)
      begin
        en_r <= 1'b0;
      end
    end
  end

  // Toggle carries the program-start event into the core domain
  always_ff @(posedge LINK.serial_clock_in or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      tgl_r <= 1'b0;
    end
    else if (prog_go)
    begin
      tgl_r <= ~tgl_r;
    end
  end

  // Array cells; content is updated at once, the timer only models busy
  for (genvar i = 0; i < `TWE_MEM_BYTES; i++)
  begin : g_cell
    always_ff @(posedge LINK.serial_clock_in)
    begin
      if (prog_go && (pg_all || (word_org ? (pg_addr[5:0] == 6'(i / 2))
                                          : (pg_addr == 7'(i)))))
      begin
        mem_r[i] <= (word_org && (i % 2 == 1)) ? pg_data[15:8] : pg_data[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core clock domain: self-timed cycle and status

  // Synchronisers for select, strap and start toggle
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      cs_s1_r <= 1'b0;
      cs_s2_r <= 1'b0;
      org_s1_r <= 1'b0;
      org_s2_r <= 1'b0;
      tg_s1_r <= 1'b0;
      tg_s2_r <= 1'b0;
      tg_s3_r <= 1'b0;
    end
    else
    begin
      cs_s1_r <= LINK.chip_select;
      cs_s2_r <= cs_s1_r;
      org_s1_r <= ORGANIZATION_SELECT;
      org_s2_r <= org_s1_r;
      tg_s1_r <= tgl_r;
      tg_s2_r <= tg_s1_r;
      tg_s3_r <= tg_s2_r;
    end
  end

  // Program cycle timer
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      busy_r <= 1'b0;
      tmr_r <= '0;
    end
    else if (tg_s2_r != tg_s3_r)
    begin
      busy_r <= 1'b1;
      tmr_r <= '0;
    end
    else if (busy_r)
    begin
      tmr_r <= tmr_r + 1'b1;
      if (tmr_r == `TWE_CNT_W'(PROG_CYCLES - 1))
      begin
        busy_r <= 1'b0;
      end
    end
  end

  // Status is armed by select low during the cycle; a cycle that ends
  // while select is still low disarms it, so a late rise shows nothing
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      armed_r <= 1'b0;
      stat_r <= 1'b0;
    end
    else
    begin
      if (tg_s2_r != tg_s3_r)
      begin
        armed_r <= 1'b0;
      end
      else if (!cs_s2_r)
      begin
        armed_r <= busy_r;
      end
      stat_r <= cs_s2_r & armed_r;
    end
  end

  // Pin drive: read data first, else ready/busy; released with select low
  assign LINK.serial_data_out = rd_act_r ? do_r : ~busy_r;
  assign LINK.serial_data_out_oe = LINK.chip_select & (rd_act_r | stat_r);
  assign BUSY = busy_r;
  assign PROG_ENABLED = en_r;
endmodule : twe_device

//--- rtl/twe_host.sv
// Host end: builds command frames, makes the serial clock, polls status
`timescale 1ns/1ps
`include "twe_consts.svh"
module twe_host #(
  parameter int unsigned POLL_LIMIT = `TWE_POLL_LIMIT_CYC
) (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic WORD_MODE,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire twe_pkg::twe_op_e CMD_OP,
  input wire logic [6:0] CMD_ADDR,
  input wire logic [15:0] CMD_DATA,
  output logic RSP_VALID,
  output logic [15:0] RSP_DATA,
  output logic RSP_TIMEOUT,
  twe_link_if.host LINK
);
  import twe_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  twe_host_st_e st_r;
  logic cs_r;
  logic clk_r;
  logic sdi_r;
  logic [2:0] ph_r;
  logic [4:0] bits_r;
  logic [25:0] tx_r;
  logic [15:0] rx_r;
  logic rd_r;
  logic prog_r;
  logic [`TWE_CNT_W-1:0] cnt_r;
  logic rsp_valid_r;
  logic [15:0] rsp_data_r;
  logic timeout_r;
  logic so_s1_r;
  logic so_s2_r;
  logic oe_s1_r;
  logic oe_s2_r;
  logic [1:0] opc;
  logic [1:0] pat;
  logic has_pat;
  logic has_data;
  logic [25:0] frame;
  logic [4:0] flen;
  logic fall;

  ////////////////////////////////////////////////////////////////////////////
  // Frame builder

  // Don't-care address bits are still sent, filled from the command address
  always_comb
  begin
    opc = `TWE_OPC_MISC;
    pat = `TWE_PAT_DISABLE;
    has_pat = 1'b1;
    has_data = 1'b0;
    unique case (CMD_OP)
      OP_READ: begin opc = `TWE_OPC_READ; has_pat = 1'b0; end
      OP_ERASE: begin opc = `TWE_OPC_ERASE; has_pat = 1'b0; end
      OP_WRITE: begin opc = `TWE_OPC_WRITE; has_pat = 1'b0; has_data = 1'b1; end
      OP_ENABLE: pat = `TWE_PAT_ENABLE;
      OP_ERASE_ALL: pat = `TWE_PAT_ERASE_ALL;
      OP_WRITE_ALL: begin pat = `TWE_PAT_WRITE_ALL; has_data = 1'b1; end
      OP_DISABLE: pat = `TWE_PAT_DISABLE;
      default: has_pat = 1'b1;
    endcase
    if (WORD_MODE)
    begin
      frame = {`TWE_START_BIT, opc, has_pat ? {pat, CMD_ADDR[3:0]} : CMD_ADDR[5:0],
               CMD_DATA, 1'b0};
      flen = 5'h03 + `TWE_ALEN_X16 + (has_data ? `TWE_DLEN_X16 : 5'h00);
    end
    else
    begin
      frame = {`TWE_START_BIT, opc, has_pat ? {pat, CMD_ADDR[4:0]} : CMD_ADDR[6:0],
               CMD_DATA[7:0], 8'h00};
      flen = 5'h03 + `TWE_ALEN_X8 + (has_data ? `TWE_DLEN_X8 : 5'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Return data pin passes two flops; half period of four leaves margin
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      so_s1_r <= 1'b0;
      so_s2_r <= 1'b0;
      oe_s1_r <= 1'b0;
      oe_s2_r <= 1'b0;
    end
    else
    begin
      so_s1_r <= LINK.serial_data_out;
      so_s2_r <= so_s1_r;
      oe_s1_r <= LINK.serial_data_out_oe;
      oe_s2_r <= oe_s1_r;
    end
  end

  assign fall = clk_r && (ph_r == `TWE_SCLK_HALF_CYC - 3'h1);
  assign CMD_READY = (st_r == H_IDLE);

  // Clock divider, shifting, gaps and status polling
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      st_r <= H_IDLE;
      cs_r <= 1'b0;
      clk_r <= 1'b0;
      sdi_r <= 1'b0;
      ph_r <= 3'h0;
      bits_r <= 5'h00;
      tx_r <= '0;
      rx_r <= 16'h0000;
      rd_r <= 1'b0;
      prog_r <= 1'b0;
      cnt_r <= '0;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 16'h0000;
      timeout_r <= 1'b0;
    end
    else
    begin
      rsp_valid_r <= 1'b0;
      cnt_r <= cnt_r + 1'b1;
      if ((st_r == H_SHIFT) || (st_r == H_RECV))
      begin
        ph_r <= ph_r + 3'h1;
        if (ph_r == `TWE_SCLK_HALF_CYC - 3'h1)
        begin
          ph_r <= 3'h0;
          clk_r <= ~clk_r;
        end
      end
      unique case (st_r)
        H_IDLE:
        begin
          if (CMD_VALID)
          begin
            cs_r <= 1'b1;
            tx_r <= {frame[24:0], 1'b0};
            sdi_r <= frame[25];
            bits_r <= flen;
            rd_r <= (CMD_OP == OP_READ);
            prog_r <= (CMD_OP == OP_ERASE) || (CMD_OP == OP_WRITE) ||
                      (CMD_OP == OP_ERASE_ALL) || (CMD_OP == OP_WRITE_ALL);
            rx_r <= 16'h0000;
            timeout_r <= 1'b0;
            ph_r <= 3'h0;
            st_r <= H_SHIFT;
          end
        end
        H_SHIFT:
        begin
          if (fall)
          begin
            sdi_r <= tx_r[25];
            tx_r <= {tx_r[24:0], 1'b0};
            bits_r <= bits_r - 5'h01;
            cnt_r <= '0;
            if (bits_r == 5'h01)
            begin
              if (rd_r)
              begin
                bits_r <= WORD_MODE ? `TWE_DLEN_X16 : `TWE_DLEN_X8;
                st_r <= H_RECV;
              end
              else
              begin
                cs_r <= 1'b0;
                st_r <= prog_r ? H_GAP : H_END;
              end
            end
          end
        end
        H_RECV:
        begin
          if (fall)
          begin
            rx_r <= {rx_r[14:0], so_s2_r};
            bits_r <= bits_r - 5'h01;
            cnt_r <= '0;
            if (bits_r == 5'h01)
            begin
              rsp_valid_r <= 1'b1;
              rsp_data_r <= {rx_r[14:0], so_s2_r};
              cs_r <= 1'b0;
              st_r <= H_END;
            end
          end
        end
        H_GAP:
        begin
          // Select low for the minimum time, then raise it to poll
          if (cnt_r >= `TWE_CNT_W'(`TWE_MIN_SELECT_LOW_CYC - 1))
          begin
            cs_r <= 1'b1;
            cnt_r <= '0;
            st_r <= H_POLL;
          end
        end
        H_POLL:
        begin
          // A refused command never starts a cycle, so the wait ends at POLL_LIMIT
          if ((oe_s2_r && so_s2_r) || (cnt_r == `TWE_CNT_W'(POLL_LIMIT - 1)))
          begin
            timeout_r <= !(oe_s2_r && so_s2_r);
            rsp_valid_r <= 1'b1;
            cs_r <= 1'b0;
            cnt_r <= '0;
            st_r <= H_END;
          end
        end
        H_END:
        begin
          if (cnt_r >= `TWE_CNT_W'(`TWE_MIN_SELECT_LOW_CYC - 1))
          begin
            st_r <= H_IDLE;
          end
        end
      endcase
    end
  end

  assign LINK.chip_select = cs_r;
  assign LINK.serial_clock_in = clk_r;
  assign LINK.serial_data_in = sdi_r;
  assign RSP_VALID = rsp_valid_r;
  assign RSP_DATA = rsp_data_r;
  assign RSP_TIMEOUT = timeout_r;
endmodule : twe_host

//--- verif/twe_link_chk.sv
// Concurrent checks on the three-wire link between host and memory
`timescale 1ns/1ps
module twe_link_chk (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic chip_select,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe
);
  logic [5:0] rise_cnt_r;
  logic [5:0] low_cnt_r;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!ARST_N);
  ////////////////////////////////////////////////////////////////////////////////
  // Serial clock rises within the frame; zero means a status poll, not a read
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      rise_cnt_r <= 6'h00;
    else if (!chip_select)
      rise_cnt_r <= 6'h00;
    else if ($rose(serial_clock_in) && rise_cnt_r != 6'h3F)
      rise_cnt_r <= rise_cnt_r + 6'h01;
  end
  // Select-low length, saturating so a long idle cannot wrap round
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      low_cnt_r <= 6'h00;
    else if (chip_select)
      low_cnt_r <= 6'h00;
    else if (low_cnt_r != 6'h3F)
      low_cnt_r <= low_cnt_r + 6'h01;
  end
  ////////////////////////////////////////////////////////////////////////////////
  chk_out_released: assert property (serial_data_out_oe |-> chip_select)
    else $error("data out driven while select low");
  chk_clock_idle_low: assert property (!chip_select |-> !serial_clock_in)
    else $error("serial clock high outside a frame");
  chk_start_bit_one: assert property (
    $rose(serial_clock_in) && rise_cnt_r == 6'h00 |-> serial_data_in)
    else $error("first bit of frame is not one");
  chk_din_stable_rise: assert property (
    chip_select && $rose(serial_clock_in) |-> $stable(serial_data_in))
    else $error("data in moved at a clock rise");
  chk_dummy_zero: assert property (
    $rose(serial_data_out_oe) && rise_cnt_r != 6'h00 |-> !serial_data_out)
    else $error("read did not open with a zero bit");
  chk_read_after_addr: assert property (
    $rose(serial_data_out_oe) && rise_cnt_r != 6'h00 |-> rise_cnt_r >= 6'h08)
    else $error("read output before address complete");
  chk_dout_on_rise: assert property (serial_data_out_oe && $past(serial_data_out_oe)
    && rise_cnt_r != 6'h00 && $changed(serial_data_out) |-> serial_clock_in)
    else $error("read data changed away from a rise");
  chk_ready_holds: assert property (serial_data_out_oe && $past(serial_data_out_oe)
    && $past(serial_data_out) && rise_cnt_r == 6'h00 |-> serial_data_out)
    else $error("ready status fell back to busy");
  chk_select_gap: assert property ($rose(chip_select) |-> low_cnt_r >= 6'd25)
    else $error("select low time too short");
  // Main traffic seen on the wire
  cov_read: cover property ($rose(serial_data_out_oe) && rise_cnt_r != 6'h00);
  cov_busy: cover property (serial_data_out_oe && rise_cnt_r == 6'h00 && !serial_data_out);
  cov_ready: cover property (serial_data_out_oe && rise_cnt_r == 6'h00 && serial_data_out);
endmodule : twe_link_chk

//--- verif/test_three_wire_eeprom_command_port.sv
// Bench joining host and memory ends, driving commands through the host
`timescale 1ns/1ps
module test_three_wire_eeprom_command_port;
  import twe_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic word_mode = 1'b0;
  logic cmd_valid = 1'b0;
  twe_op_e cmd_op = OP_READ;
  logic [6:0] cmd_addr = 7'h00;
  logic [15:0] cmd_data = 16'h0000;
  logic cmd_ready, rsp_valid, rsp_timeout, busy, prog_enabled;
  logic [15:0] rsp_data;
  int fails = 0;
  int tests_run = 0;
  twe_link_if link ();
  ////////////////////////////////////////////////////////////////////////////////
  twe_host #(.POLL_LIMIT(1000)) twe_host_inst (.CORE_CLK(core_clk), .ARST_N(arst_n),
    .WORD_MODE(word_mode), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op),
    .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
    .RSP_TIMEOUT(rsp_timeout), .LINK(link.host));
  // Short program cycle keeps the run brief; poll limit still exceeds it
  twe_device #(.PROG_CYCLES(200), .WORD_ONLY(1'b0)) twe_device_inst (.CORE_CLK(core_clk),
    .ARST_N(arst_n), .ORGANIZATION_SELECT(word_mode), .LINK(link.dev), .BUSY(busy),
    .PROG_ENABLED(prog_enabled));
  twe_link_chk twe_link_chk_inst (.CORE_CLK(core_clk), .ARST_N(arst_n),
    .chip_select(link.chip_select), .serial_clock_in(link.serial_clock_in),
    .serial_data_in(link.serial_data_in), .serial_data_out(link.serial_data_out),
    .serial_data_out_oe(link.serial_data_out_oe));
  // Core clock, 100 MHz
  always #5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Bounded wait for the host to be idle; a hang ends the run as a failure.
  // Outputs are looked at on the falling edge, where they have settled.
  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 5000);
    if (n >= 5000)
    begin
      fails++;
      print_verdict;
    end
    @(posedge core_clk);
  endtask : wait_ready
  // One command through the host handshake, optionally waiting for its response
  task automatic issue(input twe_op_e op, input logic [6:0] a, input logic [15:0] d,
                       input bit answer);
    int n;
    wait_ready;
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    n = 0;
    // Response pulse lasts one cycle, so it is caught between two rising edges
    while (answer && n < 5000)
    begin
      @(negedge core_clk);
      n++;
      if (rsp_valid === 1'b1)
        break;
    end
    if (n >= 5000)
    begin
      fails++;
      print_verdict;
    end
    wait_ready;
  endtask : issue
  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    issue(OP_READ, a, 16'h0000, 1'b1);
    check("read data", word_mode ? rsp_data : {8'h00, rsp_data[7:0]}, exp);
  endtask : rd
  // Program command; a refused one is seen as a poll timeout
  task automatic prog(input twe_op_e op, input logic [6:0] a, input logic [15:0] d,
                      input logic refused);
    issue(op, a, d, 1'b1);
    check("poll timeout", {15'h0000, rsp_timeout}, {15'h0000, refused});
    check("busy after poll", {15'h0000, busy}, 16'h0000);
  endtask : prog
  task automatic do_reset(input logic organization_select);
    @(posedge core_clk);
    arst_n <= 1'b0;
    word_mode <= organization_select;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (30) @(posedge core_clk);
    check("latch after reset", {15'h0000, prog_enabled}, 16'h0000);
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////////
  // Byte organisation first, then a reset into word organisation
  initial
  begin
    do_reset(1'b0);
    prog(OP_WRITE, 7'h03, 16'h00A5, 1'b1);
    issue(OP_ENABLE, 7'h00, 16'h0000, 1'b0);
    check("latch set", {15'h0000, prog_enabled}, 16'h0001);
    prog(OP_ERASE_ALL, 7'h00, 16'h0000, 1'b0);
    rd(7'h7F, 16'h00FF);
    rd(7'h00, 16'h00FF);
    prog(OP_WRITE, 7'h00, 16'h005A, 1'b0);
    prog(OP_WRITE, 7'h7F, 16'h00C3, 1'b0);
    rd(7'h00, 16'h005A);
    rd(7'h7F, 16'h00C3);
    prog(OP_ERASE, 7'h00, 16'h0000, 1'b0);
    rd(7'h00, 16'h00FF);
    rd(7'h7F, 16'h00C3);
    prog(OP_WRITE_ALL, 7'h00, 16'h0096, 1'b0);
    rd(7'h10, 16'h0096);
    rd(7'h7F, 16'h0096);
    check("latch kept", {15'h0000, prog_enabled}, 16'h0001);
    issue(OP_DISABLE, 7'h00, 16'h0000, 1'b0);
    check("latch cleared", {15'h0000, prog_enabled}, 16'h0000);
    prog(OP_WRITE, 7'h10, 16'h0000, 1'b1);
    prog(OP_ERASE, 7'h10, 16'h0000, 1'b1);
    rd(7'h10, 16'h0096);
    do_reset(1'b1);
    prog(OP_WRITE, 7'h3F, 16'h1111, 1'b1);
    issue(OP_ENABLE, 7'h00, 16'h0000, 1'b0);
    prog(OP_WRITE, 7'h3F, 16'hA55A, 1'b0);
    prog(OP_WRITE, 7'h00, 16'h1234, 1'b0);
    rd(7'h3F, 16'hA55A);
    rd(7'h00, 16'h1234);
    prog(OP_ERASE_ALL, 7'h00, 16'h0000, 1'b0);
    rd(7'h3F, 16'hFFFF);
    print_verdict;
  end
endmodule : test_three_wire_eeprom_command_port
